// >>> reset_supervisor_pkg.sv
// constants, types and reset values of the reset and supply supervisor
package reset_supervisor_pkg;

    // clock
    localparam int CLK_PERIOD_NS = 10;

    // initial power-on reset pulse: least width, rounded up to whole cycles
    localparam int POR_PULSE_NS = 150;
    localparam int POR_PULSE_CYC = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 5;
    localparam logic [PULSE_W-1:0] POR_PULSE_LOAD = PULSE_W'(POR_PULSE_CYC - 1);

    // precise regulator monitor: least gap before it may reassert
    localparam int REARM_NS = 10000;
    localparam int REARM_CYC = (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REARM_W = 10;
    localparam logic [REARM_W-1:0] REARM_LOAD = REARM_W'(REARM_CYC);

    // low-voltage trip points: base + code * step, in millivolts
    localparam int LV_TRIP_BASE_MV = 1700;
    localparam int LV_TRIP_STEP_MV = 250;
    localparam int LV_TRIP_MAX_MV = 5450;
    localparam int AHV_TRIP_MV = 5750;
    localparam int TRIP_W = 4;
    localparam logic [TRIP_W-1:0] LV_TRIP_CODE_MAX =
        TRIP_W'((LV_TRIP_MAX_MV - LV_TRIP_BASE_MV) / LV_TRIP_STEP_MV);

    // watchdog counter width
    localparam int WDT_W = 16;

    // synchroniser bit positions
    localparam int SYNC_W = 7;
    localparam int SYN_POR = 0;
    localparam int SYN_EXT = 1;
    localparam int SYN_PDIG = 2;
    localparam int SYN_PANA = 3;
    localparam int SYN_ALOW = 4;
    localparam int SYN_DLOW = 5;
    localparam int SYN_AHIGH = 6;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 7'h02;

    // reset status bit positions
    localparam int ST_W = 7;
    localparam int ST_PREC = 0;
    localparam int ST_EXT = 1;
    localparam int ST_SW = 2;
    localparam int ST_WDT = 3;
    localparam int ST_ALOW = 4;
    localparam int ST_DLOW = 5;
    localparam int ST_AHIGH = 6;

    // voltage interrupt bit positions
    localparam int IRQ_W = 3;
    localparam int IRQ_ALOW = 0;
    localparam int IRQ_DLOW = 1;
    localparam int IRQ_AHIGH = 2;

    typedef enum logic [1:0] {
        PM_ACTIVE = 2'h0,
        PM_SLEEP = 2'h1,
        PM_HIBERNATE = 2'h3
    } power_mode_e;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic bootDone;
        logic devReset;
        logic [PULSE_W-1:0] pulseCnt;
        logic precLatch;
        logic [REARM_W-1:0] rearmCnt;
        logic wdtEn;
        logic [WDT_W-1:0] wdtCnt;
        logic [ST_W-1:0] status;
        logic [IRQ_W-1:0] irqFlags;
        logic [IRQ_W-1:0] irqOut;
        logic wakeReq;
        logic initMonEn;
        logic precDigEn;
        logic precAnaEn;
        logic lvMonEn;
        logic [TRIP_W-1:0] aTrip;
        logic [TRIP_W-1:0] dTrip;
    } sup_state_s;

    localparam sup_state_s SUP_STATE_RST = '{
        sync1: SYNC_IDLE,
        sync2: SYNC_IDLE,
        devReset: 1'b1,
        pulseCnt: POR_PULSE_LOAD,
        initMonEn: 1'b1,
        default: '0
    };

endpackage : reset_supervisor_pkg

// >>> reset_source_supervisor.sv
// reset source combiner, supply monitor control, voltage interrupts and watchdog
//
// What this block does
// - initial power-on monitor trip gives a reset of at least 150 ns, longer while ramping
// - after boot the initial monitor is off; the precise regulator monitor supervises
// - a precise regulator monitor trip resets exactly like the initial power-on reset
// - the precise monitor reset cannot reassert within 10 us of deasserting
// - software has no control that turns off the digital precise monitor
// - disabling the analog regulator also disables the analog precise monitor
// - precise monitor off in sleep and hibernate, except during sleep buzz windows
// - low-voltage trip points 1.70 V to 5.45 V in 250 mV steps
// - analog high-voltage interrupt uses a fixed 5.75 V trip level
// - each low-voltage detector can be set to reset the device instead of interrupting
// - voltage monitors stay off until boot completes after power-on reset; in sleep only when buzzed
// - an interrupt caught while buzzing first wakes the device, then is recognised
// - external reset pin held low keeps the device in power-on style reset
// - external reset pin works in sleep and hibernate; pulled up when undriven
// - software reset request gives a reset equal to the power-on reset
// - a separate block bit stops the software reset request from resetting
// - watchdog not cleared within the programmed timeout resets the device
// - watchdog off after power-on; once enabled it stays on until next power-on
// - reset status records causes and voltage events; cleared only by power-on
// - the device reset output resets processor, peripherals and their registers
`timescale 1ns/1ps

module reset_source_supervisor
    import reset_supervisor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnTrip,
    input wire logic externalResetN,
    input wire logic precDigLow,
    input wire logic precAnaLow,
    input wire logic vddaBelowTrip,
    input wire logic vdddBelowTrip,
    input wire logic vddaAboveHigh,
    input wire logic bootComplete,
    input wire power_mode_e powerMode,
    input wire logic buzzWindow,
    input wire logic analogRegEnable,
    input wire logic [TRIP_W-1:0] analogLowTripSel,
    input wire logic [TRIP_W-1:0] digitalLowTripSel,
    input wire logic analogLowResetMode,
    input wire logic digitalLowResetMode,
    input wire logic [IRQ_W-1:0] irqClear,
    input wire logic softwareResetRequest,
    input wire logic softwareResetBlock,
    input wire logic wdtClear,
    input wire logic wdtEnableSet,
    input wire logic [WDT_W-1:0] wdtTimeout,
    output logic deviceReset,
    output logic initMonitorEnable,
    output logic precDigEnable,
    output logic precAnaEnable,
    output logic voltMonitorEnable,
    output logic [TRIP_W-1:0] analogLowTripCode,
    output logic [TRIP_W-1:0] digitalLowTripCode,
    output logic [IRQ_W-1:0] voltIrq,
    output logic wakeRequest,
    output logic [ST_W-1:0] resetStatus,
    output logic watchdogEnabled
);

    sup_state_s state_reg;
    sup_state_s state_next;

    logic porEvent;
    logic extActive;
    logic precTrip;
    logic swTrip;
    logic wdtTrip;
    logic aLow;
    logic dLow;
    logic aHigh;
    logic lvReset;
    logic anyTrip;
    logic monOn;
    logic [IRQ_W-1:0] irqSet;
    logic [ST_W-1:0] statusSet;

    always_comb begin
        state_next = state_reg;

        // two-stage synchronisers for everything from outside the clock domain
        state_next.sync1 = {vddaAboveHigh, vdddBelowTrip, vddaBelowTrip,
                            precAnaLow, precDigLow, externalResetN, powerOnTrip};
        state_next.sync2 = state_reg.sync1;

        // initial monitor only counts before boot has completed
        porEvent = state_reg.sync2[SYN_POR] & state_reg.initMonEn;
        // pin is live in every power mode, pull-up is outside the logic
        extActive = ~state_reg.sync2[SYN_EXT];
        // precise trip blocked while the rearm gap runs
        precTrip = ((state_reg.sync2[SYN_PDIG] & state_reg.precDigEn)
                    | (state_reg.sync2[SYN_PANA] & state_reg.precAnaEn))
                   & (state_reg.rearmCnt == '0);
        swTrip = softwareResetRequest & ~softwareResetBlock;
        wdtTrip = state_reg.wdtEn & (state_reg.wdtCnt >= wdtTimeout);

        // voltage comparators only count while their monitors are on
        aLow = state_reg.sync2[SYN_ALOW] & state_reg.lvMonEn;
        dLow = state_reg.sync2[SYN_DLOW] & state_reg.lvMonEn;
        aHigh = state_reg.sync2[SYN_AHIGH] & state_reg.lvMonEn;
        lvReset = (aLow & analogLowResetMode) | (dLow & digitalLowResetMode);

        anyTrip = porEvent | extActive | precTrip | swTrip | wdtTrip | lvReset;

        // every source loads the same power-on pulse stretcher
        if (anyTrip) begin
            state_next.pulseCnt = POR_PULSE_LOAD;
        end else if (state_reg.pulseCnt != '0) begin
            state_next.pulseCnt = state_reg.pulseCnt - PULSE_W'(1);
        end
        // registered, so release always lands on a clock edge
        state_next.devReset = anyTrip | (state_reg.pulseCnt != '0);

        // boot handshake, taken only outside reset
        if (bootComplete & ~state_reg.devReset) begin
            state_next.bootDone = 1'b1;
        end
        state_next.initMonEn = ~state_next.bootDone;

        // monitors run after boot in active mode, or in sleep while buzzed
        monOn = state_reg.bootDone & ((powerMode == PM_ACTIVE)
                | ((powerMode == PM_SLEEP) & buzzWindow));
        // no software input reaches the digital precise enable
        state_next.precDigEn = monOn;
        state_next.precAnaEn = monOn & analogRegEnable;
        state_next.lvMonEn = monOn;

        // trip codes: every 4-bit code is a legal step up to the top point
        state_next.aTrip = (analogLowTripSel > LV_TRIP_CODE_MAX) ?
                           LV_TRIP_CODE_MAX : analogLowTripSel;
        state_next.dTrip = (digitalLowTripSel > LV_TRIP_CODE_MAX) ?
                           LV_TRIP_CODE_MAX : digitalLowTripSel;

        // rearm gap starts when a reset caused by the precise monitor ends
        if (state_reg.rearmCnt != '0) begin
            state_next.rearmCnt = state_reg.rearmCnt - REARM_W'(1);
        end
        if (precTrip) begin
            state_next.precLatch = 1'b1;
        end else if (state_reg.devReset & ~state_next.devReset & state_reg.precLatch) begin
            state_next.precLatch = 1'b0;
            state_next.rearmCnt = REARM_LOAD;
        end

        // watchdog enable is sticky until power-on
        if (wdtEnableSet) begin
            state_next.wdtEn = 1'b1;
        end
        if (state_reg.devReset | wdtClear | ~state_reg.wdtEn) begin
            state_next.wdtCnt = '0;
        end else if (~wdtTrip) begin
            state_next.wdtCnt = state_reg.wdtCnt + WDT_W'(1);
        end

        // voltage interrupts: a detector in reset mode raises no interrupt
        irqSet = '0;
        irqSet[IRQ_ALOW] = aLow & ~analogLowResetMode;
        irqSet[IRQ_DLOW] = dLow & ~digitalLowResetMode;
        irqSet[IRQ_AHIGH] = aHigh;
        // set wins over a clear in the same cycle
        state_next.irqFlags = (state_reg.irqFlags & ~irqClear) | irqSet;
        if (state_reg.devReset) begin
            state_next.irqFlags = '0;
        end
        // outside active mode an event asks for wakeup first
        if (powerMode == PM_ACTIVE) begin
            state_next.wakeReq = 1'b0;
        end else if (irqSet != '0) begin
            state_next.wakeReq = 1'b1;
        end
        state_next.irqOut = (powerMode == PM_ACTIVE) ? state_next.irqFlags : '0;

        // status keeps causes across every reset except power-on
        statusSet = '0;
        statusSet[ST_PREC] = precTrip;
        statusSet[ST_EXT] = extActive;
        statusSet[ST_SW] = swTrip;
        statusSet[ST_WDT] = wdtTrip;
        statusSet[ST_ALOW] = aLow;
        statusSet[ST_DLOW] = dLow;
        statusSet[ST_AHIGH] = aHigh;
        state_next.status = state_reg.status | statusSet;

        // a power-on event restarts boot and clears the sticky state
        if (porEvent) begin
            state_next.bootDone = 1'b0;
            state_next.initMonEn = 1'b1;
            state_next.wdtEn = 1'b0;
            state_next.status = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SUP_STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign deviceReset = state_reg.devReset;
    assign initMonitorEnable = state_reg.initMonEn;
    assign precDigEnable = state_reg.precDigEn;
    assign precAnaEnable = state_reg.precAnaEn;
    assign voltMonitorEnable = state_reg.lvMonEn;
    assign analogLowTripCode = state_reg.aTrip;
    assign digitalLowTripCode = state_reg.dTrip;
    assign voltIrq = state_reg.irqOut;
    assign wakeRequest = state_reg.wakeReq;
    assign resetStatus = state_reg.status;
    assign watchdogEnabled = state_reg.wdtEn;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // last cycle after a precise-caused release at which a precise trip is still refused
    localparam int REARM_GAP_LAST = REARM_CYC - 1;

    AST_POR_PULSE_WIDTH: assert property (
        $rose(deviceReset) |-> deviceReset [*8] ##1 deviceReset [*7])
        else $error("device reset pulse shorter than the power-on minimum");

    AST_INIT_MON_OFF: assert property (
        $rose(state_reg.bootDone) |-> !initMonitorEnable ##1 !initMonitorEnable)
        else $error("initial monitor still enabled after boot");

    AST_PREC_RESET: assert property (
        precTrip |=> deviceReset ##1 deviceReset)
        else $error("precise monitor trip did not reset the device");

    AST_PREC_REARM: assert property (
        not (($fell(deviceReset) && $past(state_reg.precLatch))
            ##[0:REARM_GAP_LAST] precTrip))
        else $error("precise monitor reasserted inside the rearm gap");

    AST_PREC_SLEEP: assert property (
        (powerMode == PM_HIBERNATE || (powerMode == PM_SLEEP && !buzzWindow))
        |=> !precDigEnable && !precAnaEnable && !voltMonitorEnable)
        else $error("monitor left enabled in a low-power mode");

    AST_ANA_REG_OFF: assert property (
        !analogRegEnable |=> !precAnaEnable)
        else $error("analog precise monitor on with analog regulator off");

    AST_LV_RESET_MODE: assert property (
        (aLow && analogLowResetMode && !state_reg.irqFlags[IRQ_ALOW])
        |=> deviceReset && !state_reg.irqFlags[IRQ_ALOW])
        else $error("analog low detector in reset mode did not reset");

    AST_LV_AFTER_BOOT: assert property (
        !state_reg.bootDone |=> !voltMonitorEnable)
        else $error("voltage monitors enabled before boot");

    AST_WAKE_FIRST: assert property (
        (powerMode != PM_ACTIVE && irqSet != '0)
        |=> wakeRequest && voltIrq == '0)
        else $error("interrupt recognised before wakeup");

    AST_EXT_RESET: assert property (
        !externalResetN [*3] |=> deviceReset)
        else $error("device left reset while external reset held low");

    AST_SW_RESET: assert property (
        (softwareResetRequest && !softwareResetBlock) |=> deviceReset)
        else $error("software reset request did not reset the device");

    AST_SW_BLOCK: assert property (
        (softwareResetRequest && softwareResetBlock && !anyTrip && state_reg.pulseCnt == '0)
        |=> !deviceReset)
        else $error("blocked software reset request reset the device");

    AST_WDT_TIMEOUT: assert property (
        (state_reg.wdtEn && !wdtClear && state_reg.wdtCnt >= wdtTimeout)
        |=> deviceReset)
        else $error("watchdog timeout did not reset");

    AST_WDT_STICKY: assert property (
        (watchdogEnabled && !porEvent) |=> watchdogEnabled)
        else $error("watchdog enable cleared without power-on");

    AST_STATUS_KEEP: assert property (
        (resetStatus[ST_EXT] && !porEvent) |=> resetStatus[ST_EXT])
        else $error("reset status lost without power-on");

    AST_SYNC_RELEASE: assert property (
        (!anyTrip && state_reg.pulseCnt == '0) |=> !deviceReset)
        else $error("device reset held with no source active");

    AST_DIG_LV_RESET: assert property (
        (dLow && digitalLowResetMode && !state_reg.irqFlags[IRQ_DLOW])
        |=> deviceReset && !state_reg.irqFlags[IRQ_DLOW])
        else $error("digital low detector in reset mode did not reset");

    AST_ALOW_IRQ: assert property (
        (aLow && !analogLowResetMode && !state_reg.devReset)
        |=> state_reg.irqFlags[IRQ_ALOW])
        else $error("analog low supply raised no interrupt");

    AST_DLOW_IRQ: assert property (
        (dLow && !digitalLowResetMode && !state_reg.devReset)
        |=> state_reg.irqFlags[IRQ_DLOW])
        else $error("digital low supply raised no interrupt");

    AST_AHIGH_IRQ: assert property (
        (aHigh && !state_reg.devReset) |=> state_reg.irqFlags[IRQ_AHIGH])
        else $error("analog high supply raised no interrupt");

    AST_TRIP_CODE: assert property (
        (analogLowTripSel <= LV_TRIP_CODE_MAX && digitalLowTripSel <= LV_TRIP_CODE_MAX)
        |=> analogLowTripCode == $past(analogLowTripSel)
            && digitalLowTripCode == $past(digitalLowTripSel))
        else $error("trip code not passed to the comparators");

    AST_PREC_DIG_ON: assert property (
        (state_reg.bootDone && powerMode == PM_ACTIVE) |=> precDigEnable)
        else $error("digital precise monitor off in active mode");

    AST_PREC_BUZZ: assert property (
        (state_reg.bootDone && powerMode == PM_SLEEP && buzzWindow)
        |=> precDigEnable && voltMonitorEnable)
        else $error("monitors not enabled during a buzz window");

    AST_IRQ_HIDDEN: assert property (
        (powerMode != PM_ACTIVE) |=> voltIrq == '0)
        else $error("interrupt shown outside active mode");

    AST_POR_TRIP: assert property (
        porEvent |=> deviceReset)
        else $error("power-on monitor trip did not reset");

    AST_POR_CLEARS: assert property (
        porEvent |=> !watchdogEnabled && resetStatus == '0 && initMonitorEnable)
        else $error("power-on event did not clear sticky state");

    AST_RESET_CLEARS_IRQ: assert property (
        deviceReset |=> voltIrq == '0)
        else $error("interrupt kept through device reset");

    AST_WDT_CLEAR: assert property (
        wdtClear |=> state_reg.wdtCnt == '0)
        else $error("watchdog clear did not restart the count");

    AST_STATUS_SW: assert property (
        (swTrip && !porEvent) |=> resetStatus[ST_SW])
        else $error("software reset cause not recorded");

    COV_EXT_RESET: cover property (!externalResetN ##3 deviceReset ##[1:40] !deviceReset);
    COV_WDT_RESET: cover property (wdtTrip ##1 deviceReset);
    COV_SLEEP_WAKE: cover property (powerMode == PM_SLEEP && buzzWindow ##[1:8] wakeRequest);
    COV_PREC_REARM: cover property ($fell(deviceReset) && $past(state_reg.precLatch));

endmodule : reset_source_supervisor

// >>> supply_env_model.sv
// far-side model: external reset source with pull-up and a firmware watchdog kicker
`timescale 1ns/1ps

module supply_env_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic holdLow,
    input wire logic kickEn,
    output logic externalResetN,
    output logic wdtClear
);
    logic driveLow;
    logic [9:0] gapCnt;
    logic [2:0] kickCnt;

    // an undriven pin rests high through its pull-up
    assign externalResetN = driveLow ? 1'b0 : 1'b1;
    // firmware clears the watchdog every 8 cycles while running
    assign wdtClear = kickEn && (kickCnt == 3'h0);

    always_ff @(posedge clk) begin
        kickCnt <= rst ? 3'h0 : kickCnt + 3'h1;
        if (rst) begin
            driveLow <= 1'b0;
            gapCnt <= 10'h000;
        end else if (driveLow && !holdLow) begin
            driveLow <= 1'b0;
            gapCnt <= 10'h3e8; // 1000 cycles before pulling low again
        end else if (gapCnt != 10'h000) begin
            gapCnt <= gapCnt - 10'h001;
        end else if (holdLow) begin
            driveLow <= 1'b1;
        end
    end
endmodule : supply_env_model

// >>> tb.sv
// self-checking testbench of the reset source supervisor
`timescale 1ns/1ps

module tb
    import reset_supervisor_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerOnTrip = 1'b0, precDigLow = 1'b0, precAnaLow = 1'b0, bootComplete = 1'b0;
    logic buzzWindow = 1'b0, analogRegEnable = 1'b1, wdtEnableSet = 1'b0;
    logic softwareResetRequest = 1'b0, softwareResetBlock = 1'b0, holdLow = 1'b0, kickEn = 1'b0;
    logic [2:0] cmpHit = 3'h0, irqClear = 3'h0;
    logic [1:0] lvMode = 2'h0;
    logic [3:0] aSel = 4'h0, dSel = 4'h0, aCode, dCode;
    logic [15:0] wdtTimeout = 16'h0040;
    power_mode_e powerMode = PM_ACTIVE;
    logic deviceReset, initMonitorEnable, precDigEnable, precAnaEnable, voltMonitorEnable;
    logic wakeRequest, watchdogEnabled, externalResetN, wdtClear;
    logic [2:0] voltIrq;
    logic [6:0] resetStatus;
    int fails = 0, n_compared = 0, n;

    always #5 clk = ~clk;

    supply_env_model u_env (.clk(clk), .rst(rst), .holdLow(holdLow), .kickEn(kickEn),
        .externalResetN(externalResetN), .wdtClear(wdtClear));

    reset_source_supervisor u_dut (.clk(clk), .rst(rst), .powerOnTrip(powerOnTrip),
        .externalResetN(externalResetN), .precDigLow(precDigLow), .precAnaLow(precAnaLow),
        .vddaBelowTrip(cmpHit[0]), .vdddBelowTrip(cmpHit[1]), .vddaAboveHigh(cmpHit[2]),
        .bootComplete(bootComplete), .powerMode(powerMode), .buzzWindow(buzzWindow),
        .analogRegEnable(analogRegEnable), .analogLowTripSel(aSel), .digitalLowTripSel(dSel),
        .analogLowResetMode(lvMode[0]), .digitalLowResetMode(lvMode[1]), .irqClear(irqClear),
        .softwareResetRequest(softwareResetRequest), .softwareResetBlock(softwareResetBlock),
        .wdtClear(wdtClear), .wdtEnableSet(wdtEnableSet), .wdtTimeout(wdtTimeout),
        .deviceReset(deviceReset), .initMonitorEnable(initMonitorEnable),
        .precDigEnable(precDigEnable), .precAnaEnable(precAnaEnable),
        .voltMonitorEnable(voltMonitorEnable), .analogLowTripCode(aCode),
        .digitalLowTripCode(dCode), .voltIrq(voltIrq), .wakeRequest(wakeRequest),
        .resetStatus(resetStatus), .watchdogEnabled(watchdogEnabled));

    function automatic logic [15:0] bit_of(input int b);
        return 16'h0001 << b;
    endfunction : bit_of

    function automatic logic [15:0] lv_mv(input logic [3:0] c);
        return 16'(LV_TRIP_BASE_MV + int'(c) * LV_TRIP_STEP_MV);
    endfunction : lv_mv

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_rst(input logic v, input int lim);
        for (int i = 0; i < lim && deviceReset !== v; i++) tick(1);
        check(16'(deviceReset), 16'(v));
    endtask : wait_rst

    task automatic no_rst(input int k);
        repeat (k) begin
            tick(1);
            check(16'(deviceReset), 16'h0000);
        end
    endtask : no_rst

    task automatic status_has(input int b);
        check(16'(resetStatus) & bit_of(b), bit_of(b));
    endtask : status_has

    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial begin
        #100000;
        fails++;
        close_out();
    end

    initial begin
        void'($urandom(32'hc9f98a13));
        tick(2);
        rst = 1'b0;
        check(16'(deviceReset), 16'h0001);
        check(16'(initMonitorEnable), 16'h0001);
        check(16'(watchdogEnabled), 16'h0000);
        check(16'(resetStatus), 16'h0000);
        powerOnTrip = 1'b1;
        tick(10);
        powerOnTrip = 1'b0;
        tick(16);
        check(16'(deviceReset), 16'h0001);
        wait_rst(1'b0, 20);
        bootComplete = 1'b1;
        tick(3);
        check(16'(initMonitorEnable), 16'h0000);
        check(16'(precDigEnable), 16'h0001);
        check(16'(voltMonitorEnable), 16'h0001);
        analogRegEnable = 1'b0;
        tick(2);
        check(16'(precAnaEnable), 16'h0000);
        check(16'(precDigEnable), 16'h0001);
        analogRegEnable = 1'b1;
        powerOnTrip = 1'b1;
        no_rst(5);
        powerOnTrip = 1'b0;
        for (int i = 0; i < 10; i++) begin
            aSel = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            dSel = ~aSel;
            tick(2);
            check(lv_mv(aCode), lv_mv(aSel));
            check(lv_mv(dCode), lv_mv(dSel));
        end
        softwareResetBlock = 1'b1;
        softwareResetRequest = 1'b1;
        no_rst(5);
        softwareResetBlock = 1'b0;
        tick(1);
        softwareResetRequest = 1'b0;
        n = 0;
        while (deviceReset === 1'b1 && n < 40) begin
            n++;
            tick(1);
        end
        check(16'(n), 16'h000f);
        status_has(ST_SW);
        tick(3);
        precDigLow = 1'b1;
        tick(2);
        precDigLow = 1'b0;
        wait_rst(1'b1, 6);
        status_has(ST_PREC);
        wait_rst(1'b0, 40);
        tick(300);
        precAnaLow = 1'b1;
        tick(2);
        precAnaLow = 1'b0;
        no_rst(8);
        tick(800);
        precAnaLow = 1'b1;
        tick(2);
        precAnaLow = 1'b0;
        wait_rst(1'b1, 6);
        wait_rst(1'b0, 40);
        tick(3);
        for (int i = 0; i < 3; i++) begin
            cmpHit[i] = 1'b1;
            tick(2);
            cmpHit[i] = 1'b0;
            tick(3);
            check(16'(voltIrq), bit_of(i));
            status_has(ST_ALOW + i);
            irqClear[i] = 1'b1;
            tick(1);
            irqClear[i] = 1'b0;
            tick(1);
            check(16'(voltIrq), 16'h0000);
        end
        for (int i = 0; i < 2; i++) begin
            lvMode[i] = 1'b1;
            cmpHit[i] = 1'b1;
            tick(2);
            cmpHit[i] = 1'b0;
            wait_rst(1'b1, 6);
            check(16'(voltIrq), 16'h0000);
            lvMode[i] = 1'b0;
            wait_rst(1'b0, 40);
            tick(3);
        end
        powerMode = PM_SLEEP;
        tick(2);
        check(16'(precDigEnable), 16'h0000);
        check(16'(voltMonitorEnable), 16'h0000);
        cmpHit[0] = 1'b1; // supply stays out longer than the buzz spacing
        tick(4);
        buzzWindow = 1'b1;
        tick(2);
        check(16'(precDigEnable), 16'h0001);
        tick(3);
        check(16'(wakeRequest), 16'h0001);
        check(16'(voltIrq), 16'h0000);
        buzzWindow = 1'b0;
        cmpHit[0] = 1'b0;
        powerMode = PM_ACTIVE;
        tick(2);
        check(16'(voltIrq), 16'h0001);
        irqClear = 3'h7;
        tick(1);
        irqClear = 3'h0;
        powerMode = PM_HIBERNATE;
        tick(2);
        check(16'(precDigEnable), 16'h0000);
        holdLow = 1'b1;
        n = 5 + $urandom % 20;
        tick(4);
        repeat (n) begin
            tick(1);
            check(16'(deviceReset), 16'h0001);
        end
        holdLow = 1'b0;
        wait_rst(1'b0, 40);
        status_has(ST_EXT);
        powerMode = PM_ACTIVE;
        wdtTimeout = 16'(20 + $urandom % 40);
        kickEn = 1'b1;
        wdtEnableSet = 1'b1;
        tick(1);
        wdtEnableSet = 1'b0;
        tick(1);
        check(16'(watchdogEnabled), 16'h0001);
        no_rst(100);
        kickEn = 1'b0;
        no_rst(10);
        wait_rst(1'b1, 70);
        kickEn = 1'b1;
        status_has(ST_WDT);
        wait_rst(1'b0, 40);
        check(16'(watchdogEnabled), 16'h0001);
        check(16'(resetStatus), 16'h007f);
        close_out();
    end
endmodule : tb
